// [verilog/xcvr_diag_regs.svh]
`ifndef XCVR_DIAG_REGS_SVH
`define XCVR_DIAG_REGS_SVH

// ----------------------------------------
// Serial bus address (7-bit form)
// ----------------------------------------
`define DEV_ADDR            7'h51

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_SOFT_CTRL       8'h6E
`define OFS_LOOPBACK        8'h6F
`define OFS_ALARM_A         8'h70
`define OFS_ALARM_RX        8'h71
`define OFS_WARN_A          8'h74
`define OFS_WARN_RX         8'h75

// ----------------------------------------
// Soft control byte fields
// ----------------------------------------
`define SC_TX_OFF_PIN_BIT   7
`define SC_SOFT_TX_OFF_BIT  6
`define SC_TX_RATE_PIN_BIT  5
`define SC_RX_RATE_PIN_BIT  4
`define SC_SOFT_RX_RATE_BIT 3
`define SC_TX_FAULT_BIT     2
`define SC_RX_LOS_BIT       1
`define SC_DATA_READY_N_BIT 0

// ----------------------------------------
// Loopback byte fields
// ----------------------------------------
`define LB_OPT_FWD_BIT      3
`define LB_OPT_BIT          2
`define LB_ELEC_FWD_BIT     1
`define LB_ELEC_BIT         0
`define LB_WIDTH            4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SOFT_BIT        1'b0
`define RST_LOOPBACK        4'h0
`define RST_FLAGS           8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SOFT_CMD_TIME_MS    100

`endif

// [verilog/xcvr_diag_pkg.sv]
`default_nettype none

package xcvr_diag_pkg;

    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] vcc;
        logic [15:0] bias;
        logic [15:0] tx_pwr;
        logic [15:0] rx_pwr;
    } mon_s;

    typedef struct packed {
        mon_s hi;
        mon_s lo;
    } thr_pair_s;

    typedef struct packed {
        thr_pair_s alarm;
        thr_pair_s warn;
    } thr_set_s;

    typedef struct packed {
        logic tx_off_pin;
        logic tx_rate_select_pin;
        logic rx_rate_select_pin;
        logic tx_fault;
        logic rx_los;
        logic data_ready_n;
    } status_pins_s;

    typedef struct packed {
        logic opt_rx_to_opt_tx;
        logic opt_rx_to_elec_rx;
        logic elec_tx_to_elec_rx;
        logic elec_tx_to_opt_tx;
    } route_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_ACK,
        ST_PTR,
        ST_WDATA,
        ST_RDATA,
        ST_RACK
    } bus_state_e;

endpackage : xcvr_diag_pkg

`default_nettype wire

// [verilog/xcvr_diag_ctrl.sv]
// Summary of operation
// - Soft commands act on hardware within 100 ms of the write completing.
// - Transmitter off when soft transmitter-off bit or transmitter-off pin is set.
// - High receive rate when soft receive-rate bit or receive rate pin is set.
// - Optical loopback bit routes received optical data to optical transmit output.
// - Electrical loopback bit routes electrical transmit data to electrical receive output.
// - Setting either loopback bit clears all other bits of the loopback byte.
// - Optical forward with loopback sends optical data to both outputs.
// - Setting optical forward sets optical loopback and clears the rest.
// - Electrical forward with loopback sends electrical data to both outputs.
// - Setting electrical forward sets electrical loopback and clears the rest.
// - Alarm byte A bits 7/6 flag temperature above high, below low.
// - Alarm byte A bits 5/4 flag supply voltage above high, below low.
// - Alarm byte A bits 3/2 flag bias current above high, below low.
// - Alarm byte A bits 1/0 flag transmit power above high, below low.
// - Alarm receive byte bits 7/6 flag receive power; bits 5-0 reserved.
// - Warning byte A mirrors alarm byte A using warning thresholds.
// - Warning receive byte bits 7/6 flag receive power; bits 5-0 reserved.
// - Temperature compares signed in 1/256 degree steps; others unsigned 16 bit.
// - Soft receive-rate bit ORs with its pin and resets to zero.
// - Soft control bit 7 reports live transmitter-off pin state.
`timescale 1ns/100ps
`default_nettype none

`include "xcvr_diag_regs.svh"

module xcvr_diag_ctrl #(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR
) (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output var  logic                        sda_out,
    output var  logic                        sda_oe_out,
    input  wire xcvr_diag_pkg::status_pins_s pins_in,
    input  wire logic                        mon_update_in,
    input  wire xcvr_diag_pkg::mon_s         mon_in,
    input  wire xcvr_diag_pkg::thr_set_s     thr_in,
    output var  logic                        tx_disable_out,
    output var  logic                        rx_rate_high_out,
    output var  xcvr_diag_pkg::route_s       route_out
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Returns {above_high, below_low}
    function automatic logic [1:0] cmp_pair(input logic [15:0] val,
                                            input logic [15:0] hi,
                                            input logic [15:0] lo,
                                            input logic        is_signed);
        logic above;
        logic below;
        above = is_signed ? ($signed(val) > $signed(hi)) : (val > hi);
        below = is_signed ? ($signed(val) < $signed(lo)) : (val < lo);
        cmp_pair = {above, below};
    endfunction : cmp_pair

    function automatic logic [7:0] flags_a(input xcvr_diag_pkg::mon_s      v,
                                           input xcvr_diag_pkg::thr_pair_s t);
        flags_a = {cmp_pair(v.temp,   t.hi.temp,   t.lo.temp,   1'b1),
                   cmp_pair(v.vcc,    t.hi.vcc,    t.lo.vcc,    1'b0),
                   cmp_pair(v.bias,   t.hi.bias,   t.lo.bias,   1'b0),
                   cmp_pair(v.tx_pwr, t.hi.tx_pwr, t.lo.tx_pwr, 1'b0)};
    endfunction : flags_a

    function automatic logic [7:0] flags_rx(input xcvr_diag_pkg::mon_s      v,
                                            input xcvr_diag_pkg::thr_pair_s t);
        flags_rx = {cmp_pair(v.rx_pwr, t.hi.rx_pwr, t.lo.rx_pwr, 1'b0), 6'h00};
    endfunction : flags_rx

    // One loopback bit per write; higher bit wins if several arrive together
    function automatic logic [`LB_WIDTH-1:0] lb_resolve(input logic [7:0] d);
        lb_resolve = `RST_LOOPBACK;
        if (d[`LB_OPT_FWD_BIT]) begin
            lb_resolve[`LB_OPT_FWD_BIT] = 1'b1;
            lb_resolve[`LB_OPT_BIT]     = 1'b1;
        end else if (d[`LB_OPT_BIT]) begin
            lb_resolve[`LB_OPT_BIT] = 1'b1;
        end else if (d[`LB_ELEC_FWD_BIT]) begin
            lb_resolve[`LB_ELEC_FWD_BIT] = 1'b1;
            lb_resolve[`LB_ELEC_BIT]     = 1'b1;
        end else if (d[`LB_ELEC_BIT]) begin
            lb_resolve[`LB_ELEC_BIT] = 1'b1;
        end
    endfunction : lb_resolve

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_reg <= 8'hC0;
            sync2_reg <= 8'hC0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            sync1_reg <= {scl_in, sda_in, pins_in};
            sync2_reg <= sync1_reg;
            scl_d_reg <= sync2_reg[7];
            sda_d_reg <= sync2_reg[6];
        end
    end

    wire                        scl_s     = sync2_reg[7];
    wire                        sda_s     = sync2_reg[6];
    wire xcvr_diag_pkg::status_pins_s pins_s = sync2_reg[5:0];
    wire                        scl_rise  = scl_s & ~scl_d_reg;
    wire                        scl_fall  = ~scl_s & scl_d_reg;
    wire                        start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire                        stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic                  soft_tx_off_reg;
    logic                  soft_rx_rate_high_reg;
    logic [`LB_WIDTH-1:0]  loopback_reg;
    logic [7:0]            alarm_a_reg;
    logic [7:0]            alarm_rx_reg;
    logic [7:0]            warn_a_reg;
    logic [7:0]            warn_rx_reg;

    wire [7:0] soft_ctrl_rd = {pins_s.tx_off_pin,
                               soft_tx_off_reg,
                               pins_s.tx_rate_select_pin,
                               pins_s.rx_rate_select_pin,
                               soft_rx_rate_high_reg,
                               pins_s.tx_fault,
                               pins_s.rx_los,
                               pins_s.data_ready_n};

    // ----------------------------------------
    // Serial bus slave
    // ----------------------------------------
    xcvr_diag_pkg::bus_state_e state_reg;
    xcvr_diag_pkg::bus_state_e after_ack_reg;
    logic [7:0]                shift_reg;
    logic [3:0]                bit_cnt_reg;
    logic [7:0]                ptr_reg;
    logic                      rw_reg;
    logic                      nack_reg;
    logic                      sda_oe_reg;
    logic                      wr_en_reg;
    logic [7:0]                wr_addr_reg;
    logic [7:0]                wr_data_reg;

    wire [7:0] rd_byte = (ptr_reg == `OFS_SOFT_CTRL) ? soft_ctrl_rd :
                         (ptr_reg == `OFS_LOOPBACK)  ? {4'h0, loopback_reg} :
                         (ptr_reg == `OFS_ALARM_A)   ? alarm_a_reg :
                         (ptr_reg == `OFS_ALARM_RX)  ? alarm_rx_reg :
                         (ptr_reg == `OFS_WARN_A)    ? warn_a_reg :
                         (ptr_reg == `OFS_WARN_RX)   ? warn_rx_reg : 8'h00;

    wire       byte_done = (bit_cnt_reg == 4'h8);
    wire       rx_state  = (state_reg == xcvr_diag_pkg::ST_DEV) |
                           (state_reg == xcvr_diag_pkg::ST_PTR) |
                           (state_reg == xcvr_diag_pkg::ST_WDATA);
    wire       addr_hit  = (shift_reg[7:1] == DEV_ADDR);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg     <= xcvr_diag_pkg::ST_IDLE;
            after_ack_reg <= xcvr_diag_pkg::ST_IDLE;
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= 4'h0;
            ptr_reg       <= 8'h00;
            rw_reg        <= 1'b0;
            nack_reg      <= 1'b0;
            sda_oe_reg    <= 1'b0;
            wr_en_reg     <= 1'b0;
            wr_addr_reg   <= 8'h00;
            wr_data_reg   <= 8'h00;
        end else begin
            wr_en_reg <= 1'b0;
            if (start_det) begin
                state_reg   <= xcvr_diag_pkg::ST_DEV;
                bit_cnt_reg <= 4'h0;
                sda_oe_reg  <= 1'b0;
            end else if (stop_det) begin
                state_reg  <= xcvr_diag_pkg::ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else if (rx_state && scl_rise && !byte_done) begin
                shift_reg   <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
                case (state_reg)
                    xcvr_diag_pkg::ST_DEV: begin
                        if (byte_done && addr_hit) begin
                            rw_reg        <= shift_reg[0];
                            sda_oe_reg    <= 1'b1;
                            state_reg     <= xcvr_diag_pkg::ST_ACK;
                            after_ack_reg <= shift_reg[0] ? xcvr_diag_pkg::ST_RDATA
                                                          : xcvr_diag_pkg::ST_PTR;
                        end else if (byte_done) begin
                            state_reg <= xcvr_diag_pkg::ST_IDLE;
                        end
                    end
                    xcvr_diag_pkg::ST_PTR: begin
                        if (byte_done) begin
                            ptr_reg       <= shift_reg;
                            sda_oe_reg    <= 1'b1;
                            state_reg     <= xcvr_diag_pkg::ST_ACK;
                            after_ack_reg <= xcvr_diag_pkg::ST_WDATA;
                        end
                    end
                    xcvr_diag_pkg::ST_WDATA: begin
                        if (byte_done) begin
                            wr_en_reg     <= 1'b1;
                            wr_addr_reg   <= ptr_reg;
                            wr_data_reg   <= shift_reg;
                            ptr_reg       <= ptr_reg + 8'h01;
                            sda_oe_reg    <= 1'b1;
                            state_reg     <= xcvr_diag_pkg::ST_ACK;
                            after_ack_reg <= xcvr_diag_pkg::ST_WDATA;
                        end
                    end
                    xcvr_diag_pkg::ST_ACK: begin
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= after_ack_reg;
                        if (after_ack_reg == xcvr_diag_pkg::ST_RDATA) begin
                            shift_reg  <= rd_byte;
                            sda_oe_reg <= ~rd_byte[7];
                            ptr_reg    <= ptr_reg + 8'h01;
                        end else begin
                            sda_oe_reg <= 1'b0;
                        end
                    end
                    xcvr_diag_pkg::ST_RDATA: begin
                        if (bit_cnt_reg == 4'h7) begin
                            sda_oe_reg <= 1'b0;
                            state_reg  <= xcvr_diag_pkg::ST_RACK;
                        end else begin
                            shift_reg   <= {shift_reg[6:0], 1'b0};
                            sda_oe_reg  <= ~shift_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                    xcvr_diag_pkg::ST_RACK: begin
                        // Host NACK ends the burst; ACK streams the next byte
                        if (nack_reg) begin
                            state_reg <= xcvr_diag_pkg::ST_IDLE;
                        end else begin
                            bit_cnt_reg <= 4'h0;
                            shift_reg   <= rd_byte;
                            sda_oe_reg  <= ~rd_byte[7];
                            ptr_reg     <= ptr_reg + 8'h01;
                            state_reg   <= xcvr_diag_pkg::ST_RDATA;
                        end
                    end
                    default: begin
                        state_reg <= state_reg;
                    end
                endcase
            end else if (scl_rise && state_reg == xcvr_diag_pkg::ST_RACK) begin
                nack_reg <= sda_s;
            end
        end
    end

    // ----------------------------------------
    // Soft commands and loopback byte
    // ----------------------------------------
    wire wr_soft = wr_en_reg & (wr_addr_reg == `OFS_SOFT_CTRL);
    wire wr_lb   = wr_en_reg & (wr_addr_reg == `OFS_LOOPBACK);

    // Writes land two cycles after the data byte, far inside the response time
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            soft_tx_off_reg       <= `RST_SOFT_BIT;
            soft_rx_rate_high_reg <= `RST_SOFT_BIT;
            loopback_reg          <= `RST_LOOPBACK;
        end else begin
            if (wr_soft) begin
                soft_tx_off_reg       <= wr_data_reg[`SC_SOFT_TX_OFF_BIT];
                soft_rx_rate_high_reg <= wr_data_reg[`SC_SOFT_RX_RATE_BIT];
            end
            if (wr_lb) begin
                loopback_reg <= lb_resolve(wr_data_reg);
            end
        end
    end

    // ----------------------------------------
    // Flag evaluation
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            alarm_a_reg  <= `RST_FLAGS;
            alarm_rx_reg <= `RST_FLAGS;
            warn_a_reg   <= `RST_FLAGS;
            warn_rx_reg  <= `RST_FLAGS;
        end else if (mon_update_in) begin
            alarm_a_reg  <= flags_a(mon_in, thr_in.alarm);
            alarm_rx_reg <= flags_rx(mon_in, thr_in.alarm);
            warn_a_reg   <= flags_a(mon_in, thr_in.warn);
            warn_rx_reg  <= flags_rx(mon_in, thr_in.warn);
        end
    end

    // ----------------------------------------
    // Hardware outputs
    // ----------------------------------------
    wire lb_opt  = loopback_reg[`LB_OPT_BIT];
    wire lb_elec = loopback_reg[`LB_ELEC_BIT];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_disable_out   <= 1'b0;
            rx_rate_high_out <= 1'b0;
            route_out        <= '0;
            sda_out          <= 1'b0;
            sda_oe_out       <= 1'b0;
        end else begin
            tx_disable_out   <= soft_tx_off_reg | pins_s.tx_off_pin;
            rx_rate_high_out <= soft_rx_rate_high_reg | pins_s.rx_rate_select_pin;
            route_out.opt_rx_to_opt_tx   <= lb_opt;
            route_out.opt_rx_to_elec_rx  <= lb_opt & loopback_reg[`LB_OPT_FWD_BIT];
            route_out.elec_tx_to_elec_rx <= lb_elec;
            route_out.elec_tx_to_opt_tx  <= lb_elec & loopback_reg[`LB_ELEC_FWD_BIT];
            sda_out    <= 1'b0;
            sda_oe_out <= sda_oe_reg;
        end
    end

endmodule : xcvr_diag_ctrl

`default_nettype wire

// [dv/xcvr_diag_ctrl_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module xcvr_diag_ctrl_assertions (
    input wire logic                        clk_in,
    input wire logic                        rst_in,
    input wire logic                        scl_in,
    input wire logic                        sda_out,
    input wire logic                        sda_oe_out,
    input wire xcvr_diag_pkg::status_pins_s pins_in,
    input wire logic                        tx_disable_out,
    input wire logic                        rx_rate_high_out,
    input wire xcvr_diag_pkg::route_s       route_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Two sync stages plus output flop, one spare cycle
    property p_tx_pin; pins_in.tx_off_pin [*5] |-> tx_disable_out; endproperty
    a_tx_pin: assert property (p_tx_pin) else $error("tx disable ignores pin");
    property p_rx_pin; pins_in.rx_rate_select_pin [*5] |-> rx_rate_high_out; endproperty
    a_rx_pin: assert property (p_rx_pin) else $error("rx rate ignores pin");
    property p_opt_fwd; route_out.opt_rx_to_elec_rx |-> route_out.opt_rx_to_opt_tx; endproperty
    a_opt_fwd: assert property (p_opt_fwd) else $error("opt fwd without loopback");
    property p_elec_fwd; route_out.elec_tx_to_opt_tx |-> route_out.elec_tx_to_elec_rx; endproperty
    a_elec_fwd: assert property (p_elec_fwd) else $error("elec fwd without loopback");
    property p_excl; not (route_out.opt_rx_to_opt_tx && route_out.elec_tx_to_elec_rx); endproperty
    a_excl: assert property (p_excl) else $error("two loopback modes at once");
    property p_reset; $fell(rst_in) |-> route_out == 4'h0 && !tx_disable_out && !rx_rate_high_out; endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_route_time; $changed(route_out) |-> !scl_in; endproperty
    a_route_time: assert property (p_route_time) else $error("route changed outside write slot");
    property p_ack_low; $changed(sda_oe_out) |-> !scl_in && !$past(scl_in); endproperty
    a_ack_low: assert property (p_ack_low) else $error("sda moved with scl high");
    property p_sda_od; sda_oe_out |-> sda_out == 1'h0; endproperty
    a_sda_od: assert property (p_sda_od) else $error("data line driven high");
    c_opt_fwd: cover property (route_out.opt_rx_to_elec_rx);
    c_elec_fwd: cover property (route_out.elec_tx_to_opt_tx);
    c_ack: cover property ($rose(sda_oe_out));
endmodule : xcvr_diag_ctrl_assertions
bind xcvr_diag_ctrl xcvr_diag_ctrl_assertions i_chk (.*);
`default_nettype wire

// [dv/xcvr_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module xcvr_host_model (
    input  wire logic clk_in,
    input  wire logic sda_wire_in,
    output var  logic scl_out,
    output var  logic sda_low_out
);
    // ----------------------------------------
    // Bus host, clock parked high between frames
    // ----------------------------------------
    initial begin
        scl_out = 1'h1;
        sda_low_out = 1'h0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
    endtask : step
    // 16 clk per bit, data moved mid low phase
    task automatic xfer_bit(input logic b, output logic r);
        scl_out <= 1'h0;
        step(4);
        sda_low_out <= !b;
        step(4);
        scl_out <= 1'h1;
        step(4);
        r = sda_wire_in;
        step(4);
    endtask : xfer_bit
    // Start and stop differ only in the data line's direction
    task automatic frame_edge(input logic is_start);
        scl_out <= 1'h0;
        step(4);
        sda_low_out <= !is_start;
        step(4);
        scl_out <= 1'h1;
        step(8);
        sda_low_out <= is_start;
        step(8);
    endtask : frame_edge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'h1, r);
        ack = !r;
    endtask : wr_byte
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'h1, r);
            d[i] = r;
        end
        xfer_bit(nack, r);
    endtask : rd_byte
endmodule : xcvr_host_model
`default_nettype wire

// [dv/transceiver_wrap_ctrl_and_diag_flags_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "xcvr_diag_regs.svh"
module transceiver_wrap_ctrl_and_diag_flags_tb;
    logic                        clk_in        = 1'h0;
    logic                        rst_in        = 1'h1;
    logic                        mon_update_in = 1'h0;
    xcvr_diag_pkg::status_pins_s pins_in       = '0;
    xcvr_diag_pkg::mon_s         mon_in        = '0;
    xcvr_diag_pkg::thr_set_s     thr_in        = '0;
    logic [15:0]                 seed          = 16'h0CD8;
    int                          fail_count    = 0;
    int                          check_count   = 0;
    wire logic                   scl_in;
    wire logic                   sda_low;
    wire logic                   sda_out;
    wire logic                   sda_oe_out;
    wire logic                   tx_disable_out;
    wire logic                   rx_rate_high_out;
    wire xcvr_diag_pkg::route_s  route_out;
    // Open drain with pull-up
    wire logic                   sda_in = !(sda_low || sda_oe_out);

    xcvr_diag_ctrl i_dut (.*);
    xcvr_host_model i_host (.clk_in(clk_in), .sda_wire_in(sda_in), .scl_out(scl_in), .sda_low_out(sda_low));

    // ----------------------------------------
    // Expectations
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] lb(input logic [7:0] v);
        return v[3] ? 8'h0C : v[2] ? 8'h04 : v[1] ? 8'h03 : v[0] ? 8'h01 : 8'h00;
    endfunction : lb
    function automatic logic [3:0] rt(input logic [7:0] l);
        return {l[2], l[2] & l[3], l[0], l[0] & l[1]};
    endfunction : rt
    function automatic logic [7:0] fa(input xcvr_diag_pkg::mon_s m, input xcvr_diag_pkg::thr_pair_s t);
        return {$signed(m.temp) > $signed(t.hi.temp), $signed(m.temp) < $signed(t.lo.temp), m.vcc > t.hi.vcc,
                m.vcc < t.lo.vcc, m.bias > t.hi.bias, m.bias < t.lo.bias, m.tx_pwr > t.hi.tx_pwr,
                m.tx_pwr < t.lo.tx_pwr};
    endfunction : fa
    function automatic logic [7:0] frx(input xcvr_diag_pkg::mon_s m, input xcvr_diag_pkg::thr_pair_s t);
        return {m.rx_pwr > t.hi.rx_pwr, m.rx_pwr < t.lo.rx_pwr, 6'h00};
    endfunction : frx

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
        logic a0, a1, a2;
        i_host.frame_edge(1'h1);
        i_host.wr_byte({`DEV_ADDR, 1'h0}, a0);
        i_host.wr_byte(ofs, a1);
        i_host.wr_byte(d, a2);
        i_host.frame_edge(1'h0);
        check({5'h00, a0, a1, a2}, 8'h07);
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] ofs, input int n, output logic [7:0] q [6]);
        logic a0, a1, a2;
        i_host.frame_edge(1'h1);
        i_host.wr_byte({`DEV_ADDR, 1'h0}, a0);
        i_host.wr_byte(ofs, a1);
        i_host.frame_edge(1'h1);
        i_host.wr_byte({`DEV_ADDR, 1'h1}, a2);
        for (int k = 0; k < n; k++) begin
            i_host.rd_byte(k == n - 1, q[k]);
        end
        i_host.frame_edge(1'h0);
        check({5'h00, a0, a1, a2}, 8'h07);
    endtask : reg_rd
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    // About 41k cycles of traffic expected
    initial begin
        repeat (100000) @(posedge clk_in);
        fail_count++;
        end_sim();
    end
    initial begin
        logic [7:0] q [6];
        logic [7:0] v;
        logic [7:0] lbv [8] = '{8'h04, 8'h01, 8'h08, 8'h02, 8'h00, 8'h0F, 8'hF4, 8'h10};
        xcvr_diag_pkg::mon_s m;
        xcvr_diag_pkg::thr_set_s t;
        logic a;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'h0;
        repeat (4) @(posedge clk_in);
        reg_rd(`OFS_SOFT_CTRL, 6, q);
        foreach (q[k]) check(q[k], 8'h00);
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            v = (i < 8) ? lbv[i] : seed[7:0];
            reg_wr(`OFS_LOOPBACK, v);
            reg_rd(`OFS_LOOPBACK, 1, q);
            check(q[0], lb(v));
            check({4'h0, route_out}, {4'h0, rt(lb(v))});
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 8'h48 : seed[7:0];
            pins_in <= (i == 0) ? 6'h00 : seed[13:8];
            reg_wr(`OFS_SOFT_CTRL, v);
            reg_rd(`OFS_SOFT_CTRL, 1, q);
            check({7'h00, tx_disable_out}, {7'h00, v[6] | pins_in.tx_off_pin});
            check({7'h00, rx_rate_high_out}, {7'h00, v[3] | pins_in.rx_rate_select_pin});
            check(q[0], {pins_in.tx_off_pin, v[6], pins_in.tx_rate_select_pin, pins_in.rx_rate_select_pin, v[3],
                         pins_in.tx_fault, pins_in.rx_los, pins_in.data_ready_n});
        end
        for (int i = 0; i < 10; i++) begin
            for (int k = 0; k < 25; k++) begin
                seed = lfsr(seed);
                if (k < 5) m[k*16 +: 16] = seed;
                else t[(k-5)*16 +: 16] = seed;
            end
            // Equal values raise nothing; -1 C tells signed from unsigned
            if (i == 0) t.alarm = {m, m};
            if (i == 1) {m.temp, t.alarm.hi.temp, t.alarm.lo.temp} = {16'hFF00, 16'h7F00, 16'h0100};
            mon_in <= m;
            thr_in <= t;
            mon_update_in <= 1'h1;
            @(posedge clk_in);
            mon_update_in <= 1'h0;
            mon_in <= ~m;
            reg_rd(`OFS_ALARM_A, 6, q);
            check(q[0], fa(m, t.alarm));
            check(q[1], frx(m, t.alarm));
            check(q[4], fa(m, t.warn));
            check(q[5], frx(m, t.warn));
        end
        reg_wr(`OFS_ALARM_A, 8'hFF);
        reg_rd(`OFS_ALARM_A, 1, q);
        check(q[0], fa(m, t.alarm));
        i_host.frame_edge(1'h1);
        i_host.wr_byte(8'hA4, a);
        i_host.frame_edge(1'h0);
        check({7'h00, a}, 8'h00);
        end_sim();
    end
endmodule : transceiver_wrap_ctrl_and_diag_flags_tb
`default_nettype wire
